// file: dsr_pkg.sv
// shared constants, types and carriers of the device signature bank
// assumes one 100 MHz bus clock and an AXI4-Lite master outside
package dsr_pkg;

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [31:0] MEM_SIZE_ADDR = 32'h1FFF_F7E0;
    localparam logic [31:0] UID_WORD0_ADDR = 32'h1FFF_F7E8;
    localparam logic [31:0] UID_WORD1_ADDR = 32'h1FFF_F7EC;
    localparam logic [31:0] UID_WORD2_ADDR = 32'h1FFF_F7F0;

    // ****************************************
    // field layout
    // ****************************************
    localparam int WORD_W = 32;
    localparam int FIELD_W = 16;
    localparam int SRAM_LSB = 16;
    localparam int FLASH_LSB = 0;
    localparam int UID_W = 96;
    localparam int ROM_DEPTH = 4;

    // ****************************************
    // word indices inside the information block
    // ****************************************
    localparam logic [1:0] IDX_SIZE = 2'h0;
    localparam logic [1:0] IDX_UID0 = 2'h1;
    localparam logic [1:0] IDX_UID1 = 2'h2;
    localparam logic [1:0] IDX_UID2 = 2'h3;

    // ****************************************
    // response codes and reset values
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
    localparam logic [15:0] DEF_SRAM_KB = 16'h0008;
    localparam logic [15:0] DEF_FLASH_KB = 16'h0020;
    // arbitrary neutral identifier
    localparam logic [95:0] DEF_UID = 96'h0123_4567_89AB_CDEF_0F1E_2D3C;

    // ****************************************
    // state encodings
    // ****************************************
    typedef enum logic [1:0] {RD_IDLE = 2'b00, RD_LOOK = 2'b01, RD_RESP = 2'b10} dsr_rd_state_t;
    typedef enum logic [0:0] {WR_IDLE = 1'b0, WR_RESP = 1'b1} dsr_wr_state_t;

    // ****************************************
    // carriers and state records
    // ****************************************
    typedef struct packed {
        logic en;
        logic [1:0] idx;
    } dsr_rom_req_t;

    typedef struct packed {
        logic [31:0] data;
    } dsr_rom_state_t;

    typedef struct packed {
        dsr_rd_state_t rd_state;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rd_hit;
        logic [1:0] rd_idx;
        dsr_wr_state_t wr_state;
        logic awready;
        logic wready;
        logic aw_done;
        logic w_done;
        logic bvalid;
        logic [1:0] bresp;
    } dsr_top_state_t;

endpackage

// file: dsr_info_rom.sv
// factory-fixed information block words with a registered read port
// assumes the caller holds the index only in the cycle of the request
module dsr_info_rom #(
    parameter logic [15:0] SRAM_KB = dsr_pkg::DEF_SRAM_KB,
    parameter logic [15:0] FLASH_KB = dsr_pkg::DEF_FLASH_KB,
    parameter logic [95:0] UID = dsr_pkg::DEF_UID
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // read port
    input dsr_pkg::dsr_rom_req_t req,
    output logic [31:0] data
);

    // ****************************************
    // contents, fixed at build time
    // ****************************************
    localparam logic [31:0] WORDS [dsr_pkg::ROM_DEPTH] = '{
        {SRAM_KB, FLASH_KB},
        UID[31:0],
        UID[63:32],
        UID[95:64]
    };

    dsr_pkg::dsr_rom_state_t s_q;
    dsr_pkg::dsr_rom_state_t s_d;

    // ****************************************
    // read path
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        if (req.en)
        begin
            s_d.data = WORDS[req.idx];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign data = s_q.data;

endmodule

// file: dsr_signature_bank.sv
// read-only device signature bank behind an AXI4-Lite slave port
// assumes a synchronous active-low reset and word-sized reads from software
//
// Overview of operation
// - bank reports memory sizes and a 96-bit identifier unique to each part.
// - every word is read out of the flash information block store.
// - each word is fixed at manufacture; no access can change it.
// - memory size word sits at its fixed address: SRAM high, flash low.
// - bits 31:16 of the size word give SRAM size in kilobytes.
// - bits 15:0 of the size word give flash size in kilobytes.
// - first identifier word returns identifier bits 31:0.
// - second identifier word returns identifier bits 63:32.
// - third identifier word, after the second, returns bits 95:64.
module dsr_signature_bank #(
    parameter logic [15:0] SRAM_KB = dsr_pkg::DEF_SRAM_KB,
    parameter logic [15:0] FLASH_KB = dsr_pkg::DEF_FLASH_KB,
    parameter logic [95:0] UID = dsr_pkg::DEF_UID
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    // write data channel
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // write response channel
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // read address channel
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    // read data channel
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready
);

    dsr_pkg::dsr_top_state_t s_q;
    dsr_pkg::dsr_top_state_t s_d;
    dsr_pkg::dsr_rom_req_t rom_req;
    logic [31:0] rom_data;
    logic ar_take;
    logic dec_hit;
    logic [1:0] dec_idx;

    // ****************************************
    // address decode
    // ****************************************
    // low address bits are dropped: only whole words are served
    always_comb
    begin
        dec_hit = 1'b1;
        dec_idx = dsr_pkg::IDX_SIZE;
        unique case (araddr[31:2])
            dsr_pkg::MEM_SIZE_ADDR[31:2]: dec_idx = dsr_pkg::IDX_SIZE;
            dsr_pkg::UID_WORD0_ADDR[31:2]: dec_idx = dsr_pkg::IDX_UID0;
            dsr_pkg::UID_WORD1_ADDR[31:2]: dec_idx = dsr_pkg::IDX_UID1;
            dsr_pkg::UID_WORD2_ADDR[31:2]: dec_idx = dsr_pkg::IDX_UID2;
            default: dec_hit = 1'b0;
        endcase
    end

    assign ar_take = arvalid && s_q.arready;

    // ****************************************
    // information block store
    // ****************************************
    // words come from the fixed store, never from writable flops
    dsr_info_rom #(
        .SRAM_KB(SRAM_KB),
        .FLASH_KB(FLASH_KB),
        .UID(UID)
    ) u_info_rom (
        .aclk(aclk),
        .aresetn(aresetn),
        .req(rom_req),
        .data(rom_data)
    );

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        rom_req = '0;
        // read side
        unique case (s_q.rd_state)
            dsr_pkg::RD_IDLE:
            begin
                s_d.arready = 1'b1;
                if (ar_take)
                begin
                    s_d.arready = 1'b0;
                    s_d.rd_hit = dec_hit;
                    s_d.rd_idx = dec_idx;
                    rom_req.en = dec_hit;
                    rom_req.idx = dec_idx;
                    s_d.rd_state = dsr_pkg::RD_LOOK;
                end
            end
            dsr_pkg::RD_LOOK:
            begin
                s_d.rvalid = 1'b1;
                // size word and identifier words pass whole
                s_d.rdata = s_q.rd_hit ? rom_data : dsr_pkg::RDATA_RST;
                s_d.rresp = s_q.rd_hit ? dsr_pkg::RESP_OKAY : dsr_pkg::RESP_SLVERR;
                s_d.rd_state = dsr_pkg::RD_RESP;
            end
            dsr_pkg::RD_RESP:
            begin
                if (rready)
                begin
                    s_d.rvalid = 1'b0;
                    s_d.rd_state = dsr_pkg::RD_IDLE;
                end
            end
            default:
            begin
                s_d.rvalid = 1'b0;
                s_d.arready = 1'b0;
                s_d.rd_state = dsr_pkg::RD_IDLE;
            end
        endcase
        // write side: data is taken and dropped
        unique case (s_q.wr_state)
            dsr_pkg::WR_IDLE:
            begin
                s_d.aw_done = s_q.aw_done || (awvalid && s_q.awready);
                s_d.w_done = s_q.w_done || (wvalid && s_q.wready);
                if (s_d.aw_done && s_d.w_done)
                begin
                    s_d.awready = 1'b0;
                    s_d.wready = 1'b0;
                    s_d.aw_done = 1'b0;
                    s_d.w_done = 1'b0;
                    s_d.bvalid = 1'b1;
                    s_d.bresp = dsr_pkg::RESP_SLVERR;
                    s_d.wr_state = dsr_pkg::WR_RESP;
                end
                else
                begin
                    s_d.awready = !s_d.aw_done;
                    s_d.wready = !s_d.w_done;
                end
            end
            dsr_pkg::WR_RESP:
            begin
                if (bready)
                begin
                    s_d.bvalid = 1'b0;
                    s_d.wr_state = dsr_pkg::WR_IDLE;
                end
            end
        endcase
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_q <= '0;
            s_q.rd_state <= dsr_pkg::RD_IDLE;
            s_q.wr_state <= dsr_pkg::WR_IDLE;
            s_q.rdata <= dsr_pkg::RDATA_RST;
            s_q.rresp <= dsr_pkg::RESP_OKAY;
            s_q.bresp <= dsr_pkg::RESP_OKAY;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rdata = s_q.rdata;
    assign rresp = s_q.rresp;

    // ****************************************
    // checks
    // ****************************************
    default clocking chk_cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_read_of(logic [29:0] word);
        arvalid && arready && araddr[31:2] == word;
    endsequence

    sequence s_answer_ok;
        rvalid && rresp == dsr_pkg::RESP_OKAY;
    endsequence

    sequence s_write_pair;
        (awvalid && awready && wvalid && wready) ##1 (bvalid && bresp == dsr_pkg::RESP_SLVERR);
    endsequence

    sequence s_look_at(logic [1:0] idx);
        s_q.rd_state == dsr_pkg::RD_LOOK && s_q.rd_hit && s_q.rd_idx == idx;
    endsequence

    sequence s_unmapped_take;
        arvalid && arready && !dec_hit;
    endsequence

    sequence s_read_done;
        rvalid && rready;
    endsequence

    sequence s_write_done;
        bvalid && bready;
    endsequence

    chk_read_from_store: assert property (arvalid && arready |-> ##2 rvalid)
    else $error("read answer not two cycles after address");

    chk_word_fixed: assert property (s_look_at(dsr_pkg::IDX_UID2)
        |-> rom_data == UID[95:64])
    else $error("store word differs from factory value");

    chk_size_word_ok: assert property (s_read_of(dsr_pkg::MEM_SIZE_ADDR[31:2]) |-> ##2 s_answer_ok)
    else $error("size word not answered okay");

    chk_sram_field: assert property (s_read_of(dsr_pkg::MEM_SIZE_ADDR[31:2])
        |-> ##2 rdata[dsr_pkg::SRAM_LSB +: dsr_pkg::FIELD_W] == SRAM_KB)
    else $error("sram size field wrong");

    chk_flash_field: assert property (s_read_of(dsr_pkg::MEM_SIZE_ADDR[31:2])
        |-> ##2 rdata[dsr_pkg::FLASH_LSB +: dsr_pkg::FIELD_W] == FLASH_KB)
    else $error("flash size field wrong");

    chk_uid_low_word: assert property (s_read_of(dsr_pkg::UID_WORD0_ADDR[31:2])
        |-> ##2 s_answer_ok and ##2 rdata == UID[31:0])
    else $error("identifier bits 31:0 wrong");

    chk_uid_mid_word: assert property (s_read_of(dsr_pkg::UID_WORD1_ADDR[31:2])
        |-> ##2 s_answer_ok and ##2 rdata == UID[63:32])
    else $error("identifier bits 63:32 wrong");

    chk_uid_high_word: assert property (s_read_of(dsr_pkg::UID_WORD2_ADDR[31:2])
        |-> ##2 s_answer_ok and ##2 rdata == UID[95:64])
    else $error("identifier bits 95:64 wrong");

    chk_write_refused: assert property ((awvalid && awready && wvalid && wready) |-> s_write_pair)
    else $error("write not refused with slave error");

    chk_read_held: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read answer dropped before taken");

    chk_size_whole: assert property (s_read_of(dsr_pkg::MEM_SIZE_ADDR[31:2])
        |-> ##2 rdata == {SRAM_KB, FLASH_KB})
    else $error("size word not whole");

    chk_unmapped_error: assert property (s_unmapped_take
        |-> ##2 rvalid && rresp == dsr_pkg::RESP_SLVERR && rdata == dsr_pkg::RDATA_RST)
    else $error("unmapped read not refused");

    chk_low_bits_dropped: assert property (arvalid && arready && dec_hit && araddr[1:0] != 2'h0
        |-> ##2 s_answer_ok)
    else $error("unaligned mapped read not answered okay");

    chk_store_size: assert property (s_look_at(dsr_pkg::IDX_SIZE)
        |-> rom_data == {SRAM_KB, FLASH_KB})
    else $error("store size word wrong");

    chk_store_low: assert property (s_look_at(dsr_pkg::IDX_UID0)
        |-> rom_data == UID[31:0])
    else $error("store low identifier word wrong");

    chk_store_mid: assert property (s_look_at(dsr_pkg::IDX_UID1)
        |-> rom_data == UID[63:32])
    else $error("store middle identifier word wrong");

    chk_ar_busy: assert property (arvalid && arready
        |=> !arready)
    else $error("read address open while busy");

    chk_read_drop: assert property (s_read_done
        |=> !rvalid)
    else $error("read answer held after taken");

    chk_ar_reopen: assert property (s_read_done
        |=> ##1 arready)
    else $error("read address not reopened");

    chk_rresp_coded: assert property (rvalid
        |-> rresp == dsr_pkg::RESP_OKAY || rresp == dsr_pkg::RESP_SLVERR)
    else $error("read response code illegal");

    chk_write_slverr: assert property (bvalid
        |-> bresp == dsr_pkg::RESP_SLVERR)
    else $error("write response not slave error");

    chk_write_closed: assert property (bvalid
        |-> !awready && !wready)
    else $error("write channels open during response");

    chk_write_held: assert property (bvalid && !bready
        |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

    chk_write_drop: assert property (s_write_done
        |=> !bvalid)
    else $error("write response held after taken");

    chk_write_reopen: assert property (s_write_done
        |=> ##1 awready && wready)
    else $error("write channels not reopened");

    chk_write_no_read: assert property (awvalid && awready && !arvalid && s_q.rd_state == dsr_pkg::RD_IDLE
        |=> s_q.rd_state == dsr_pkg::RD_IDLE)
    else $error("write started a read");

    chk_reset_quiet: assert property ($rose(aresetn)
        |-> !rvalid && !bvalid && rdata == dsr_pkg::RDATA_RST)
    else $error("outputs busy right after reset");

    chk_ready_after_reset: assert property ($rose(aresetn)
        |=> arready && awready && wready)
    else $error("channels not open after reset");

    chk_rdata_idle_hold: assert property (s_q.rd_state != dsr_pkg::RD_LOOK
        |=> $stable(rdata))
    else $error("read data moved outside an answer");

endmodule

// file: tb_top.sv
// self-checking bench for the device signature bank
// assumes the bank answers reads two cycles after the address is taken
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // bench parameters and expectations
    // ****************************************
    localparam logic [15:0] T_SRAM = 16'h0014;
    localparam logic [15:0] T_FLASH = 16'h0180;
    // arbitrary identifier for this bench
    localparam logic [95:0] T_UID = 96'hA5C3_1E27_4B90_D6F8_3C71_E20D;
    localparam logic [31:0] HOLE_ADDR = 32'h1FFF_F7E4;

    // ****************************************
    // signals
    // ****************************************
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [31:0] awaddr = 32'h0000_0000;
    logic [2:0] awprot = 3'h0;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0] wstrb = 4'hF;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [31:0] araddr = 32'h0000_0000;
    logic [2:0] arprot = 3'h0;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    int bad_count = 0;
    int n_checks = 0;
    logic [31:0] addr_tab [4];

    always #5 aclk = ~aclk;

    dsr_signature_bank #(
        .SRAM_KB(T_SRAM),
        .FLASH_KB(T_FLASH),
        .UID(T_UID)
    ) i_dsr_signature_bank (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awprot(awprot),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arprot(arprot),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready)
    );

    // ****************************************
    // reporting
    // ****************************************
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // ****************************************
    // bus tasks
    // ****************************************
    task automatic wait_set(ref logic sig, input string what, output int n);
        n = 0;
        do
        begin
            @(posedge aclk);
            n++;
        end
        while (sig !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            bad_count++;
            $display("BAD %s expected handshake seen none", what);
            print_verdict();
        end
    endtask

    task automatic read_expect(input string name, input logic [31:0] addr, input logic [31:0] exp_d,
                               input logic [1:0] exp_r, input int hold = 0);
        int n;
        araddr <= addr;
        arvalid <= 1'b1;
        wait_set(arready, "arready", n);
        arvalid <= 1'b0;
        repeat (hold) @(posedge aclk);
        rready <= 1'b1;
        wait_set(rvalid, "rvalid", n);
        rready <= 1'b0;
        check({name, "_data"}, rdata, exp_d);
        check({name, "_resp"}, {30'h0, rresp}, {30'h0, exp_r});
        check({name, "_latency"}, hold + n, (hold < 2) ? 32'h0000_0002 : hold + 1);
    endtask

    task automatic write_expect(input logic [31:0] addr, input logic [31:0] data, input int hold = 0);
        int n;
        bit aw_ok;
        bit w_ok;
        awaddr <= addr;
        wdata <= data;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        n = 0;
        while (!(aw_ok && w_ok) && n < 50)
        begin
            @(posedge aclk);
            n++;
            if (!aw_ok && awready === 1'b1)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_ok && wready === 1'b1)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (!(aw_ok && w_ok))
        begin
            bad_count++;
            $display("BAD awready_wready expected handshake seen none");
            print_verdict();
        end
        repeat (hold) @(posedge aclk);
        bready <= 1'b1;
        wait_set(bvalid, "bvalid", n);
        bready <= 1'b0;
        check("wr_resp", {30'h0, bresp}, {30'h0, dsr_pkg::RESP_SLVERR});
        check("wr_latency", hold + n, hold + 1);
    endtask

    // ****************************************
    // read every word
    // ****************************************
    task automatic read_all();
        read_expect("size", dsr_pkg::MEM_SIZE_ADDR, {T_SRAM, T_FLASH}, dsr_pkg::RESP_OKAY);
        read_expect("uid0", dsr_pkg::UID_WORD0_ADDR, T_UID[31:0], dsr_pkg::RESP_OKAY);
        read_expect("uid1", dsr_pkg::UID_WORD1_ADDR, T_UID[63:32], dsr_pkg::RESP_OKAY);
        read_expect("uid2", dsr_pkg::UID_WORD2_ADDR, T_UID[95:64], dsr_pkg::RESP_OKAY);
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        addr_tab = '{dsr_pkg::MEM_SIZE_ADDR, dsr_pkg::UID_WORD0_ADDR, dsr_pkg::UID_WORD1_ADDR,
                     dsr_pkg::UID_WORD2_ADDR};
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check("rvalid_idle", {31'h0, rvalid}, 32'h0000_0000);
        read_all();
        read_all();
        read_expect("hole", HOLE_ADDR, 32'h0000_0000, dsr_pkg::RESP_SLVERR);
        read_expect("low_bits", 32'h1FFF_F7EB, T_UID[31:0], dsr_pkg::RESP_OKAY);
        foreach (addr_tab[i])
            write_expect(addr_tab[i], ~addr_tab[i]);
        write_expect(dsr_pkg::UID_WORD1_ADDR, 32'h0000_0000);
        read_expect("uid2_slow", dsr_pkg::UID_WORD2_ADDR, T_UID[95:64], dsr_pkg::RESP_OKAY, 3);
        write_expect(dsr_pkg::MEM_SIZE_ADDR, 32'hFFFF_FFFF, 2);
        read_all();
        print_verdict();
    end
endmodule
